/* verilog/fbs_slave.sv */
// Behaviour
// - station address 1..125 accepted; unassigned or invalid means address 126
// - silence longer than watchdog time forces substitute values; limit 60000 ms
// - watchdog disabled: missing traffic never applies substitute values
// - module status option adds 6 input bytes, one ok bit per slot
// - status/command option adds 2-byte status input and 2-byte command output
// - suppression off: all-zero exchange deactivates every output
// - suppression on: all-zero exchange ignored, outputs hold previous state
// - extra diagnostics append 12 bytes, 2 bits for each of 48 slots
// - diagnostic offset 0 or 1 shifts module 1 to diagnostic 0 or 1
// - changing status, command, diagnostic or offset options restarts the link
// - extra bus monitoring acts on outputs only, together with the watchdog
// - application redundancy: redundant unit may use its own station address
// - media redundancy: shared address, only the active unit transmits
// - service address 1..119; redundant unit uses primary plus 128
`timescale 1ns/10ps
module fbs_slave
  import fbs_pkg::*;
#(
  parameter int CYCLES_PER_MS = fbs_pkg::CYC_PER_MS
) (
  input  wire logic        REF_CLK,
  input  wire logic        RST_B,
  input  wire logic        PSEL,
  input  wire logic        PENABLE,
  input  wire logic        PWRITE,
  input  wire logic [7:0]  PADDR,
  input  wire logic [31:0] PWDATA,
  output logic      [31:0] PRDATA,
  output logic             PREADY,
  output logic             PSLVERR,
  input  wire logic        REDUNDANT_UNIT,
  input  wire logic        ACTIVE_UNIT,
  input  wire logic        RX_START,
  input  wire logic [6:0]  RX_DEST,
  input  wire logic        RX_DX,
  input  wire logic        RX_VALID,
  input  wire logic [7:0]  RX_DATA,
  input  wire logic        RX_END,
  input  wire logic        RX_GOOD,
  output logic [6:0]       STATION_ADDR,
  output logic [7:0]       SERVICE_ADDR,
  input  wire logic [4:0]  OUT_RADDR,
  output logic [7:0]       OUT_RDATA,
  output logic [15:0]      CMD_WORD,
  output logic             SUBST_ACTIVE,
  output logic             OUTPUTS_CLEARED,
  output logic             BUS_RESTART,
  input  wire logic [47:0] MODULE_OK,
  input  wire logic [15:0] STATUS_WORD,
  input  wire logic [95:0] SLOT_DIAG,
  input  wire logic        TX_REQ,
  input  wire logic        DIAG_REQ,
  output logic             TX_VALID,
  output logic [7:0]       TX_DATA,
  input  wire logic        TX_READY,
  output logic [4:0]       INPUT_EXTRA_LEN,
  output logic [4:0]       DIAG_EXTRA_LEN
);
  import fbs_pkg::*;

  function automatic logic sta_ok(input logic [6:0] a);
    sta_ok = (a >= STA_ADDR_MIN) && (a <= STA_ADDR_MAX);
  endfunction : sta_ok

  logic                  rst_s1_q;
  logic                  rst_n;
  logic                  strap_done_q;
  logic                  red_q;
  logic [CTRL_WIDTH-1:0] ctrl_q;
  logic [6:0]            sta_q;
  logic [6:0]            sta_red_q;
  logic [15:0]           wd_ms_q;
  logic [6:0]            svc_q;
  logic [7:0]            subst_q;
  logic                  restart_q;
  fbs_rx_type            rx_q;
  logic [5:0]            idx_q;
  logic                  nz_q;
  logic [15:0]           cmd_stage_q;
  logic [15:0]           cmd_q;
  logic                  bank_q;
  logic                  clear_q;
  logic                  sub_q;
  logic [7:0]            out_q;
  fbs_tx_type            tx_q;
  logic [95:0]           sh_q;
  logic [4:0]            left_q;
  logic [7:0]            ram_rdata;
  logic                  wd_expired;

  // reset release synchroniser
  always_ff @(posedge REF_CLK or negedge RST_B) begin
    if (!RST_B) begin
      rst_s1_q <= 1'b0;
      rst_n    <= 1'b0;
    end else begin
      rst_s1_q <= 1'b1;
      rst_n    <= rst_s1_q;
    end
  end

  // redundancy strap caught once after release
  always_ff @(posedge REF_CLK or negedge rst_n) begin
    if (!rst_n) begin
      strap_done_q <= 1'b0;
      red_q        <= 1'b0;
    end else if (!strap_done_q) begin
      strap_done_q <= 1'b1;
      red_q        <= REDUNDANT_UNIT;
    end
  end

  // apb decode
  wire        apb_acc   = PSEL && PENABLE;
  wire        apb_wr    = apb_acc && PWRITE;
  wire        hit_ctrl  = (PADDR == REG_CTRL);
  wire        hit_addr  = (PADDR == REG_ADDR);
  wire        hit_wd    = (PADDR == REG_WDTIME);
  wire        hit_svc   = (PADDR == REG_SVCADDR);
  wire        hit_sub   = (PADDR == REG_SUBST);
  wire        hit_stat  = (PADDR == REG_STATUS);
  wire        hit_cmd   = (PADDR == REG_CMD);
  wire        mapped    = hit_ctrl | hit_addr | hit_wd | hit_svc | hit_sub | hit_stat | hit_cmd;
  wire [7:0]  ctrl_new  = PWDATA[7:0];
  wire [6:0]  svc_new   = PWDATA[6:0];
  wire [15:0] wd_new    = (PWDATA[15:0] > WD_MAX_MS) ? WD_MAX_MS : PWDATA[15:0];
  wire        svc_legal = (svc_new >= SVC_ADDR_MIN) && (svc_new <= SVC_ADDR_MAX);
  wire [7:0]  restart_mask = 8'h00 | (8'h01 << CTRL_MODSTAT) | (8'h01 << CTRL_STATCMD)
                           | (8'h01 << CTRL_ADDDIAG) | (8'h01 << CTRL_DIAGOFS);
  wire        opt_change = apb_wr && hit_ctrl && (((ctrl_new ^ ctrl_q) & restart_mask) != 8'h00);

  always_ff @(posedge REF_CLK or negedge rst_n) begin
    if (!rst_n) begin
      ctrl_q    <= CTRL_RESET;
      sta_q     <= 7'h00;
      sta_red_q <= 7'h00;
      wd_ms_q   <= WD_RESET_MS;
      svc_q     <= SVC_ADDR_RST;
      subst_q   <= SUBST_RESET;
      restart_q <= 1'b0;
    end else begin
      restart_q <= opt_change;
      if (apb_wr && hit_ctrl) begin
        ctrl_q <= ctrl_new;
      end
      if (apb_wr && hit_addr) begin
        sta_q     <= PWDATA[6:0];
        sta_red_q <= PWDATA[ADDR_RED_LSB+6:ADDR_RED_LSB];
      end
      if (apb_wr && hit_wd) begin
        wd_ms_q <= wd_new;
      end
      if (apb_wr && hit_svc && svc_legal) begin
        svc_q <= svc_new;
      end
      if (apb_wr && hit_sub) begin
        subst_q <= PWDATA[7:0];
      end
    end
  end

  wire [31:0] status_word = {16'h0000, 1'b0, STATION_ADDR, 5'h00, red_q, clear_q, sub_q};
  assign PRDATA  = !apb_acc || PWRITE ? 32'h00000000 :
                   hit_ctrl ? {24'h000000, ctrl_q} :
                   hit_addr ? {17'h00000, sta_red_q, 1'b0, sta_q} :
                   hit_wd   ? {16'h0000, wd_ms_q} :
                   hit_svc  ? {25'h0000000, svc_q} :
                   hit_sub  ? {24'h000000, subst_q} :
                   hit_stat ? status_word :
                   hit_cmd  ? {16'h0000, cmd_q} : 32'h00000000;
  assign PREADY  = 1'b1;
  assign PSLVERR = apb_acc && !mapped;

  wire [6:0] prim_addr = sta_ok(sta_q) ? sta_q : STA_ADDR_DFLT;
  wire [6:0] red_addr  = sta_ok(sta_red_q) ? sta_red_q : prim_addr;
  assign STATION_ADDR  = (red_q && !ctrl_q[CTRL_MEDIA]) ? red_addr : prim_addr;
  assign SERVICE_ADDR  = red_q ? ({1'b0, svc_q} + SVC_RED_ADD) : {1'b0, svc_q};

  // cyclic output telegram receive
  wire       for_me    = RX_START && (RX_DEST == STATION_ADDR);
  wire       cmd_byte  = ctrl_q[CTRL_STATCMD] && (idx_q < 6'd2);
  wire [5:0] img_idx   = ctrl_q[CTRL_STATCMD] ? idx_q - 6'd2 : idx_q;
  wire       img_we    = (rx_q == RX_RECV) && RX_VALID && !cmd_byte && (img_idx < 6'(OUT_BYTES));
  wire       rx_done   = (rx_q == RX_RECV) && RX_END && RX_GOOD;
  wire       dx_zero   = rx_done && !nz_q;
  wire       dx_ignore = dx_zero && ctrl_q[CTRL_SUPPRESS];
  wire       dx_clear  = dx_zero && !ctrl_q[CTRL_SUPPRESS];
  wire       dx_commit = rx_done && nz_q;
  wire       any_frame = for_me && (rx_q == RX_IDLE);
  wire       wd_restart = rx_done || (!ctrl_q[CTRL_BUSMON] && any_frame) || !ctrl_q[CTRL_WD_EN];

  always_ff @(posedge REF_CLK or negedge rst_n) begin
    if (!rst_n) begin
      rx_q <= RX_IDLE;
      idx_q <= 6'h00;
      nz_q <= 1'b0;
      cmd_stage_q <= 16'h0000;
    end else if (restart_q) begin
      rx_q <= RX_IDLE;
    end else begin
      case (rx_q)
        RX_IDLE: begin
          idx_q <= 6'h00;
          nz_q  <= 1'b0;
          if (RX_START) begin
            rx_q <= (for_me && RX_DX) ? RX_RECV : RX_SKIP;
          end
        end
        RX_RECV: begin
          if (RX_VALID) begin
            if (idx_q != 6'h3f) begin
              idx_q <= idx_q + 6'h01;
            end
            nz_q <= nz_q | (RX_DATA != 8'h00);
            if (cmd_byte) begin
              cmd_stage_q <= idx_q[0] ? {RX_DATA, cmd_stage_q[7:0]} : {cmd_stage_q[15:8], RX_DATA};
            end
          end
          if (RX_END) begin
            rx_q <= RX_IDLE;
          end
        end
        RX_SKIP: begin
          if (RX_END) begin
            rx_q <= RX_IDLE;
          end
        end
        default: begin
          rx_q <= RX_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge REF_CLK or negedge rst_n) begin
    if (!rst_n) begin
      bank_q  <= 1'b0;
      cmd_q   <= 16'h0000;
      clear_q <= 1'b1;
      sub_q   <= 1'b0;
    end else begin
      if (dx_commit) begin
        bank_q  <= !bank_q;
        clear_q <= 1'b0;
        if (ctrl_q[CTRL_STATCMD]) begin
          cmd_q <= cmd_stage_q;
        end
      end else if (dx_clear) begin
        clear_q <= 1'b1;
        cmd_q   <= 16'h0000;
      end
      if (wd_expired && ctrl_q[CTRL_WD_EN]) begin
        sub_q <= 1'b1;
      end else if (dx_commit || dx_clear) begin
        sub_q <= 1'b0;
      end
    end
  end

  fbs_image_ram u_ram (
    .clk   (REF_CLK),
    .we    (img_we),
    .waddr ({!bank_q, img_idx[4:0]}),
    .wdata (RX_DATA),
    .raddr ({bank_q, OUT_RADDR}),
    .rdata (ram_rdata)
  );

  fbs_watchdog #(
    .CYCLES_PER_MS (CYCLES_PER_MS)
  ) u_wd (
    .clk      (REF_CLK),
    .rst_n    (rst_n),
    .restart  (wd_restart),
    .limit_ms (wd_ms_q),
    .expired  (wd_expired)
  );

  // output image with substitute and clear applied
  always_ff @(posedge REF_CLK or negedge rst_n) begin
    if (!rst_n) begin
      out_q <= 8'h00;
    end else begin
      out_q <= sub_q ? subst_q : (clear_q ? 8'h00 : ram_rdata);
    end
  end

  assign OUT_RDATA       = out_q;
  assign CMD_WORD        = cmd_q;
  assign SUBST_ACTIVE    = sub_q;
  assign OUTPUTS_CLEARED = clear_q && !sub_q;
  assign BUS_RESTART     = restart_q;

  // extra cyclic inputs and diagnostics
  // option byte counts, transmit gate and input/diagnostic data vectors
  wire [4:0]  len_ms  = ctrl_q[CTRL_MODSTAT] ? MODSTAT_BYTES : 5'd0;
  wire [4:0]  len_sc  = ctrl_q[CTRL_STATCMD] ? STATCMD_BYTES : 5'd0;
  wire [4:0]  len_dg  = ctrl_q[CTRL_ADDDIAG] ? DIAG_BYTES : 5'd0;
  wire        may_tx  = !(ctrl_q[CTRL_MEDIA] && !ACTIVE_UNIT);
  wire [63:0] in_vec  = ctrl_q[CTRL_MODSTAT] ? {STATUS_WORD, MODULE_OK} : {48'h0, STATUS_WORD};
  wire [95:0] dg_vec  = ctrl_q[CTRL_DIAGOFS] ? {SLOT_DIAG[DIAG_BITS-3:0], 2'b00} : SLOT_DIAG;
  wire        tx_go   = (tx_q == TX_IDLE) && may_tx;

  always_ff @(posedge REF_CLK or negedge rst_n) begin
    if (!rst_n) begin
      tx_q   <= TX_IDLE;
      sh_q   <= 96'h0;
      left_q <= 5'd0;
    end else if (restart_q) begin
      tx_q   <= TX_IDLE;
      left_q <= 5'd0;
    end else begin
      case (tx_q)
        TX_IDLE: begin
          if (tx_go && TX_REQ && ((len_ms + len_sc) != 5'd0)) begin
            sh_q   <= {32'h0, in_vec};
            left_q <= len_ms + len_sc;
            tx_q   <= TX_SEND;
          end else if (tx_go && DIAG_REQ && (len_dg != 5'd0)) begin
            sh_q   <= dg_vec;
            left_q <= len_dg;
            tx_q   <= TX_SEND;
          end
        end
        TX_SEND: begin
          if (TX_READY) begin
            sh_q   <= {8'h00, sh_q[95:8]};
            left_q <= left_q - 5'd1;
            if (left_q == 5'd1) begin
              tx_q <= TX_IDLE;
            end
          end
        end
        default: begin
          tx_q <= TX_IDLE;
        end
      endcase
    end
  end

  assign TX_VALID        = (tx_q == TX_SEND);
  assign TX_DATA         = sh_q[7:0];
  assign INPUT_EXTRA_LEN = len_ms + len_sc;
  assign DIAG_EXTRA_LEN  = len_dg;
endmodule : fbs_slave

/* verilog/fbs_pkg.sv */
package fbs_pkg;
  // apb register byte offsets
  localparam logic [7:0]  REG_CTRL      = 8'h00;
  localparam logic [7:0]  REG_ADDR      = 8'h04;
  localparam logic [7:0]  REG_WDTIME    = 8'h08;
  localparam logic [7:0]  REG_SVCADDR   = 8'h0c;
  localparam logic [7:0]  REG_SUBST     = 8'h10;
  localparam logic [7:0]  REG_STATUS    = 8'h14;
  localparam logic [7:0]  REG_CMD       = 8'h18;
  // control register fields
  localparam int          CTRL_WD_EN    = 0;
  localparam int          CTRL_MODSTAT  = 1;
  localparam int          CTRL_STATCMD  = 2;
  localparam int          CTRL_SUPPRESS = 3;
  localparam int          CTRL_ADDDIAG  = 4;
  localparam int          CTRL_DIAGOFS  = 5;
  localparam int          CTRL_BUSMON   = 6;
  localparam int          CTRL_MEDIA    = 7;
  localparam int          CTRL_WIDTH    = 8;
  localparam logic [7:0]  CTRL_RESET    = 8'h00;
  // address register fields
  localparam int          ADDR_RED_LSB  = 8;
  localparam logic [6:0]  STA_ADDR_MIN  = 7'h01;
  localparam logic [6:0]  STA_ADDR_MAX  = 7'h7d;
  localparam logic [6:0]  STA_ADDR_DFLT = 7'h7e;
  localparam logic [6:0]  SVC_ADDR_MIN  = 7'h01;
  localparam logic [6:0]  SVC_ADDR_MAX  = 7'h77;
  localparam logic [7:0]  SVC_RED_ADD   = 8'h80;
  localparam logic [6:0]  SVC_ADDR_RST  = 7'h01;
  // watchdog
  localparam logic [15:0] WD_MAX_MS     = 16'hea60;
  localparam logic [15:0] WD_RESET_MS   = 16'h03e8;
  localparam int          CLK_HZ        = 125000000;
  localparam int          MS_PER_S      = 1000;
  localparam int          CYC_PER_MS    = CLK_HZ / MS_PER_S;
  // cyclic data sizes
  localparam int          OUT_BYTES     = 32;
  localparam int          SLOTS         = 48;
  localparam logic [4:0]  MODSTAT_BYTES = 5'd6;
  localparam logic [4:0]  STATCMD_BYTES = 5'd2;
  localparam logic [4:0]  DIAG_BYTES    = 5'd12;
  localparam int          DIAG_BITS     = 2 * SLOTS;
  localparam logic [7:0]  SUBST_RESET   = 8'h00;
  typedef enum logic [1:0] {
    RX_IDLE = 2'b00,
    RX_RECV = 2'b01,
    RX_SKIP = 2'b10
  } fbs_rx_type;
  typedef enum logic [0:0] {
    TX_IDLE = 1'b0,
    TX_SEND = 1'b1
  } fbs_tx_type;
endpackage : fbs_pkg

/* verilog/fbs_image_ram.sv */
`timescale 1ns/10ps
module fbs_image_ram (
  input  wire logic       clk,
  input  wire logic       we,
  input  wire logic [5:0] waddr,
  input  wire logic [7:0] wdata,
  input  wire logic [5:0] raddr,
  output logic      [7:0] rdata
);
  logic [7:0] mem [0:63];

  always_ff @(posedge clk) begin
    if (we) begin
      mem[waddr] <= wdata;
    end
    rdata <= mem[raddr];
  end
endmodule : fbs_image_ram

/* verilog/fbs_watchdog.sv */
`timescale 1ns/10ps
module fbs_watchdog #(
  parameter int CYCLES_PER_MS = 125000
) (
  input  wire logic        clk,
  input  wire logic        rst_n,
  input  wire logic        restart,
  input  wire logic [15:0] limit_ms,
  output logic             expired
);
  logic [16:0] div_q;
  logic [15:0] ms_q;
  wire         tick = (div_q == 17'(CYCLES_PER_MS - 1));

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      div_q <= 17'h00000;
      ms_q  <= 16'h0000;
    end else if (restart) begin
      div_q <= 17'h00000;
      ms_q  <= 16'h0000;
    end else begin
      div_q <= tick ? 17'h00000 : div_q + 17'h00001;
      if (tick && !expired) begin
        ms_q <= ms_q + 16'h0001;
      end
    end
  end

  assign expired = (ms_q >= limit_ms);
endmodule : fbs_watchdog

/* testbench/fbs_slave_properties.sv */
`timescale 1ns/10ps
module fbs_slave_properties
  import fbs_pkg::*;
#(
  parameter int CYCLES_PER_MS = 10
) (
  input  wire logic        REF_CLK,
  input  wire logic        RST_B,
  input  wire logic        PSEL,
  input  wire logic        PENABLE,
  input  wire logic        PWRITE,
  input  wire logic [7:0]  PADDR,
  input  wire logic [31:0] PWDATA,
  input  wire logic        REDUNDANT_UNIT,
  input  wire logic        ACTIVE_UNIT,
  input  wire logic        RX_START,
  input  wire logic [6:0]  RX_DEST,
  input  wire logic        RX_DX,
  input  wire logic        RX_VALID,
  input  wire logic [7:0]  RX_DATA,
  input  wire logic        RX_END,
  input  wire logic        RX_GOOD,
  input  wire logic [6:0]  STATION_ADDR,
  input  wire logic        SUBST_ACTIVE,
  input  wire logic        OUTPUTS_CLEARED,
  input  wire logic        BUS_RESTART,
  input  wire logic        TX_REQ,
  input  wire logic        DIAG_REQ,
  input  wire logic        TX_VALID,
  input  wire logic [7:0]  TX_DATA,
  input  wire logic        TX_READY,
  input  wire logic [4:0]  DIAG_EXTRA_LEN
);
  logic [7:0]  ctrl_q;
  logic [6:0]  addr_q;
  logic [15:0] wd_q;
  logic        rx_on_q;
  logic        nz_q;
  int unsigned quiet_q;
  wire         wr = PSEL && PENABLE && PWRITE;
  wire         hit = RX_START && RX_DX && RX_DEST == STATION_ADDR && !rx_on_q;
  wire         fin = RX_END && RX_GOOD && rx_on_q;
  wire         zero_end = fin && !nz_q;
  always_ff @(posedge REF_CLK or negedge RST_B) begin
    if (!RST_B) begin
      ctrl_q <= CTRL_RESET;
      addr_q <= 7'h00;
      wd_q <= WD_RESET_MS;
      rx_on_q <= 1'b0;
      nz_q <= 1'b0;
      quiet_q <= 0;
    end else begin
      if (wr && PADDR == REG_CTRL) ctrl_q <= PWDATA[7:0];
      if (wr && PADDR == REG_ADDR) addr_q <= PWDATA[6:0];
      if (wr && PADDR == REG_WDTIME) wd_q <= (PWDATA[15:0] > WD_MAX_MS) ? WD_MAX_MS : PWDATA[15:0];
      rx_on_q <= hit || (rx_on_q && !RX_END);
      nz_q <= !hit && (nz_q || (RX_VALID && RX_DATA != 8'h00));
      quiet_q <= fin ? 0 : quiet_q + 1;
    end
  end
  default clocking cb @(posedge REF_CLK); endclocking
  default disable iff (!RST_B);
  station_addr_a: assert property (
    !REDUNDANT_UNIT |-> STATION_ADDR == ((addr_q inside {[STA_ADDR_MIN:STA_ADDR_MAX]}) ?
      addr_q : STA_ADDR_DFLT)) else $error("station address wrong");
  diag_len_a: assert property (
    DIAG_EXTRA_LEN == (ctrl_q[CTRL_ADDDIAG] ? DIAG_BYTES : 5'h00)) else $error("diag length wrong");
  wd_off_a: assert property (
    $rose(SUBST_ACTIVE) |-> $past(ctrl_q[CTRL_WD_EN])) else $error("substitution while disabled");
  wd_time_a: assert property (
    $rose(SUBST_ACTIVE) |-> quiet_q >= 32'(wd_q) * CYCLES_PER_MS) else $error("substitution early");
  restart_a: assert property (
    wr && PADDR == REG_CTRL && ((PWDATA[7:0] ^ ctrl_q) & 8'h36) != 8'h00 |-> ##[1:2] BUS_RESTART)
    else $error("no link restart");
  clear_a: assert property (
    zero_end && !ctrl_q[CTRL_SUPPRESS] |-> ##[1:2] OUTPUTS_CLEARED) else $error("clear missed");
  keep_a: assert property (
    zero_end && ctrl_q[CTRL_SUPPRESS] && !OUTPUTS_CLEARED |=> !OUTPUTS_CLEARED [*3])
    else $error("suppressed clear acted");
  restore_a: assert property (
    fin && nz_q |-> ##[1:2] (!SUBST_ACTIVE && !OUTPUTS_CLEARED)) else $error("no restore");
  media_tx_a: assert property (
    (TX_REQ || DIAG_REQ) && ctrl_q[CTRL_MEDIA] && !ACTIVE_UNIT && !TX_VALID |=> !TX_VALID)
    else $error("passive unit sent");
  tx_hold_a: assert property (
    TX_VALID && !TX_READY |=> TX_VALID && $stable(TX_DATA)) else $error("byte not held");
  cover property ($rose(SUBST_ACTIVE));
  cover property (zero_end && ctrl_q[CTRL_SUPPRESS]);
  cover property (BUS_RESTART);
endmodule : fbs_slave_properties
bind fbs_slave fbs_slave_properties #(.CYCLES_PER_MS(CYCLES_PER_MS)) chk (
  .REF_CLK, .RST_B, .PSEL, .PENABLE, .PWRITE, .PADDR, .PWDATA, .REDUNDANT_UNIT, .ACTIVE_UNIT,
  .RX_START, .RX_DEST, .RX_DX, .RX_VALID, .RX_DATA, .RX_END, .RX_GOOD, .STATION_ADDR,
  .SUBST_ACTIVE, .OUTPUTS_CLEARED, .BUS_RESTART, .TX_REQ, .DIAG_REQ, .TX_VALID, .TX_DATA,
  .TX_READY, .DIAG_EXTRA_LEN);

/* testbench/fbs_dp_master.sv */
`timescale 1ns/10ps
module fbs_dp_master (
  input  wire logic       clk,
  output logic            rx_start,
  output logic [6:0]      rx_dest,
  output logic            rx_dx,
  output logic            rx_valid,
  output logic [7:0]      rx_data,
  output logic            rx_end,
  output logic            rx_good,
  input  wire logic       tx_valid,
  input  wire logic [7:0] tx_data,
  output logic            tx_ready
);
  logic [7:0] got[$];
  initial begin
    {rx_start, rx_dx, rx_valid, rx_end, rx_good, tx_ready} = 6'h00;
    rx_dest = 7'h00;
    rx_data = 8'h00;
  end
  task automatic send(input logic [6:0] dst, input logic [7:0] b[$], input logic good);
    @(posedge clk);
    rx_start <= 1'b1;
    rx_dest <= dst;
    rx_dx <= 1'b1;
    foreach (b[i]) begin
      @(posedge clk);
      rx_start <= 1'b0;
      rx_valid <= 1'b1;
      rx_data <= b[i];
    end
    @(posedge clk);
    rx_start <= 1'b0;
    rx_valid <= 1'b0;
    rx_data <= ~rx_data;
    rx_end <= 1'b1;
    rx_good <= good;
    @(posedge clk);
    rx_end <= 1'b0;
    rx_good <= 1'b0;
    rx_dx <= 1'b0;
    rx_dest <= ~dst;
  endtask : send
  // sink stalls every other cycle
  always @(posedge clk) begin
    tx_ready <= ~tx_ready;
    if (tx_valid && tx_ready) got.push_back(tx_data);
  end
endmodule : fbs_dp_master

/* testbench/fbs_slave_test.sv */
`timescale 1ns/10ps
`define CHK(a, e) begin n_compared++; if ((a) !== (e)) begin bad_count++; \
  $display("Error at %0t: got %h expected %h", $time, (a), (e)); end end
module fbs_slave_test;
  import fbs_pkg::*;
  typedef struct packed {
    logic [7:0]  a;
    logic [31:0] d;
    logic [31:0] r;
    logic        e;
    logic [6:0]  s;
  } fbs_row_type;
  fbs_row_type rows [8] = '{
    '{REG_WDTIME, 32'h0000ffff, 32'h0000ea60, 1'b0, STA_ADDR_DFLT},
    '{REG_WDTIME, 32'h3, 32'h3, 1'b0, STA_ADDR_DFLT},
    '{REG_SVCADDR, 32'h78, 32'h1, 1'b0, STA_ADDR_DFLT},
    '{REG_SVCADDR, 32'h77, 32'h77, 1'b0, STA_ADDR_DFLT},
    '{REG_ADDR, 32'h7f, 32'h7f, 1'b0, STA_ADDR_DFLT},
    '{REG_ADDR, 32'h7d, 32'h7d, 1'b0, 7'h7d},
    '{8'h1c, 32'h5, 32'h0, 1'b1, 7'h7d},
    '{REG_ADDR, 32'h5, 32'h5, 1'b0, 7'h05}};
  logic REF_CLK = 1'b0, RST_B = 1'b0, PSEL = 1'b0, PENABLE = 1'b0, PWRITE = 1'b0;
  logic ACTIVE_UNIT = 1'b0, TX_REQ = 1'b0, DIAG_REQ = 1'b0, REDUNDANT_UNIT = 1'b0, errv;
  logic [7:0] PADDR = 8'h00;
  logic [31:0] PWDATA = 32'h0, PRDATA, rdv;
  logic [4:0] OUT_RADDR = 5'h00, INPUT_EXTRA_LEN, DIAG_EXTRA_LEN;
  logic [47:0] MODULE_OK = 48'h5a3c_0f81_e7d2;
  logic [15:0] STATUS_WORD = 16'hc6a9, CMD_WORD;
  logic [95:0] SLOT_DIAG = 96'h9e37_1b5d_c0f2_4a86_63e1_d75b;
  logic [6:0] RX_DEST, STATION_ADDR;
  logic [7:0] RX_DATA, TX_DATA, OUT_RDATA, SERVICE_ADDR;
  logic PREADY, PSLVERR, RX_START, RX_DX, RX_VALID, RX_END, RX_GOOD, SUBST_ACTIVE;
  logic OUTPUTS_CLEARED, BUS_RESTART, TX_VALID, TX_READY;
  int bad_count = 0, n_compared = 0;
  fbs_slave #(.CYCLES_PER_MS(10)) uut (.REF_CLK, .RST_B, .PSEL, .PENABLE, .PWRITE, .PADDR,
    .PWDATA, .PRDATA, .PREADY, .PSLVERR, .REDUNDANT_UNIT, .ACTIVE_UNIT, .RX_START,
    .RX_DEST, .RX_DX, .RX_VALID, .RX_DATA, .RX_END, .RX_GOOD, .STATION_ADDR, .SERVICE_ADDR,
    .OUT_RADDR, .OUT_RDATA, .CMD_WORD, .SUBST_ACTIVE, .OUTPUTS_CLEARED, .BUS_RESTART,
    .MODULE_OK, .STATUS_WORD, .SLOT_DIAG, .TX_REQ, .DIAG_REQ, .TX_VALID, .TX_DATA, .TX_READY,
    .INPUT_EXTRA_LEN, .DIAG_EXTRA_LEN);
  fbs_dp_master dp (.clk(REF_CLK), .rx_start(RX_START), .rx_dest(RX_DEST), .rx_dx(RX_DX),
    .rx_valid(RX_VALID), .rx_data(RX_DATA), .rx_end(RX_END), .rx_good(RX_GOOD),
    .tx_valid(TX_VALID), .tx_data(TX_DATA), .tx_ready(TX_READY));
  always #4 REF_CLK = ~REF_CLK;
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge REF_CLK);
    PSEL <= 1'b1;
    PWRITE <= w;
    PADDR <= a;
    PWDATA <= d;
    @(posedge REF_CLK);
    PENABLE <= 1'b1;
    @(posedge REF_CLK);
    while (PREADY !== 1'b1) @(posedge REF_CLK);
    rdv = PRDATA;
    errv = PSLVERR;
    PSEL <= 1'b0;
    PENABLE <= 1'b0;
  endtask : apb
  task automatic frm(input logic [6:0] dst, input logic [7:0] b[$]);
    dp.send(dst, b, 1'b1);
    repeat (4) @(posedge REF_CLK);
  endtask : frm
  task automatic look(input logic [4:0] i);
    OUT_RADDR <= i;
    repeat (3) @(posedge REF_CLK);
  endtask : look
  task automatic txq(input logic diag, input int n, input logic [95:0] e);
    dp.got.delete();
    @(posedge REF_CLK);
    TX_REQ <= !diag;
    DIAG_REQ <= diag;
    @(posedge REF_CLK);
    TX_REQ <= 1'b0;
    DIAG_REQ <= 1'b0;
    for (int k = 0; k < 100 && dp.got.size() < n; k++) @(posedge REF_CLK);
    repeat (4) @(posedge REF_CLK);
    `CHK(dp.got.size(), n)
    foreach (dp.got[i]) `CHK(dp.got[i], e[8*i +: 8])
  endtask : txq
  task automatic rst;
    RST_B <= 1'b0;
    repeat (10) @(posedge REF_CLK);
    RST_B <= 1'b1;
    repeat (3) @(posedge REF_CLK);
  endtask : rst
  task automatic final_report;
    $display("compared %0d mismatches %0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : final_report
  initial begin
    repeat (20000) @(posedge REF_CLK);
    bad_count++;
    final_report();
  end
  initial begin
    rst();
    foreach (rows[i]) begin
      apb(1'b1, rows[i].a, rows[i].d);
      apb(1'b0, rows[i].a, 32'h0);
      `CHK({rdv, errv, STATION_ADDR}, {rows[i].r, rows[i].e, rows[i].s})
    end
    `CHK(SERVICE_ADDR, 8'h77)
    $display("registers done");
    apb(1'b1, REG_SUBST, 32'h3c);
    apb(1'b1, REG_CTRL, 32'h04);
    frm(7'h05, {8'h34, 8'h12, 8'ha5, 8'h5a});
    frm(7'h09, {8'h00, 8'h00, 8'h00, 8'h00});
    look(5'h01);
    `CHK({CMD_WORD, OUT_RDATA, OUTPUTS_CLEARED}, {16'h1234, 8'h5a, 1'b0})
    frm(7'h05, {8'h00, 8'h00, 8'h00, 8'h00});
    look(5'h01);
    `CHK({CMD_WORD, OUT_RDATA, OUTPUTS_CLEARED}, {16'h0000, 8'h00, 1'b1})
    apb(1'b1, REG_CTRL, 32'h0c);
    frm(7'h05, {8'h01, 8'h00, 8'h66, 8'h77});
    frm(7'h05, {8'h00, 8'h00, 8'h00, 8'h00});
    look(5'h01);
    `CHK({CMD_WORD, OUT_RDATA, OUTPUTS_CLEARED}, {16'h0001, 8'h77, 1'b0})
    $display("frames done");
    for (int o = 0; o < 2; o++) begin
      apb(1'b1, REG_CTRL, 32'h16 | (o << 5));
      @(posedge REF_CLK);
      `CHK({INPUT_EXTRA_LEN, DIAG_EXTRA_LEN}, {5'd8, 5'd12})
      txq(1'b0, 8, {32'h0, STATUS_WORD, MODULE_OK});
      txq(1'b1, 12, SLOT_DIAG << (2 * o));
    end
    apb(1'b1, REG_CTRL, 32'h82);
    txq(1'b0, 0, 96'h0);
    ACTIVE_UNIT <= 1'b1;
    txq(1'b0, 6, {48'h0, MODULE_OK});
    $display("inputs done");
    apb(1'b1, REG_CTRL, 32'h01);
    repeat (5) begin
      frm(7'h05, {8'h00, 8'h44});
      repeat (10) @(posedge REF_CLK);
    end
    `CHK(SUBST_ACTIVE, 1'b0)
    repeat (60) @(posedge REF_CLK);
    look(5'h01);
    `CHK({SUBST_ACTIVE, OUT_RDATA}, {1'b1, 8'h3c})
    frm(7'h05, {8'h11, 8'h22});
    look(5'h01);
    `CHK({SUBST_ACTIVE, OUT_RDATA}, {1'b0, 8'h22})
    apb(1'b1, REG_CTRL, 32'h00);
    repeat (100) @(posedge REF_CLK);
    `CHK(SUBST_ACTIVE, 1'b0)
    apb(1'b1, REG_CTRL, 32'h41);
    repeat (4) begin
      dp.send(7'h05, {8'h11, 8'h22}, 1'b0);
      repeat (15) @(posedge REF_CLK);
    end
    `CHK(SUBST_ACTIVE, 1'b1)
    $display("watchdog done");
    REDUNDANT_UNIT <= 1'b1;
    rst();
    `CHK(STATION_ADDR, STA_ADDR_DFLT)
    `CHK({SUBST_ACTIVE, OUTPUTS_CLEARED, CMD_WORD}, {2'b01, 16'h0})
    apb(1'b0, REG_WDTIME, 32'h0);
    `CHK(rdv, {16'h0, WD_RESET_MS})
    apb(1'b1, REG_ADDR, 32'h0905);
    apb(1'b0, REG_STATUS, 32'h0);
    `CHK({rdv, STATION_ADDR, SERVICE_ADDR}, {32'h0906, 7'h09, 8'h81})
    apb(1'b1, REG_CTRL, 32'h80);
    apb(1'b0, REG_CMD, 32'h0);
    `CHK({rdv, STATION_ADDR}, {32'h0, 7'h05})
    $display("reset done");
    final_report();
  end
endmodule : fbs_slave_test
